/* File: shared/shbd_pkg.sv */
// Constants and types for the shared bus phase decoder
package shbd_pkg;
  localparam int BUS_W = 16;
  localparam int ADDR_W = 11;
  localparam int BE_W = 4;
  localparam int NARROW_W = 8;
  // Field positions on the shared lines during an address phase
  localparam int BE_LSB = 12;
  localparam int BE_MSB = 15;
  localparam int SKIP_BIT = 11;
  localparam int WIDE_A_MSB = 10;
  localparam int WIDE_A_LSB = 2;
  localparam int HIGH_A_MSB = 2;
  localparam int HIGH_A_LSB = 0;
  localparam int ADDR_HIGH_LSB = 8;
  // Reset values
  localparam logic [BUS_W-1:0] BUS_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [BE_W-1:0] BE_RST = 4'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;
  // Single byte enable for narrow mode
  localparam logic [BE_W-1:0] BE_ONE = 4'h1;
  // Reference clock
  localparam int CLK_MHZ = 50;
  localparam int SYNC_STAGES = 2;

  // Narrow-mode address sequence
  typedef enum logic [1:0] {
    SEQ_FIRST = 2'b01,
    SEQ_SECOND = 2'b10
  } shbd_seq_t;
endpackage : shbd_pkg

/* File: shared/shbd_phase_if.sv */
// Carrier between phase decoder and address assembler
`timescale 1ns/1ps
interface shbd_phase_if;
  logic cmd_phase;
  logic wide_mode;
  logic [shbd_pkg::BUS_W-1:0] line;
  logic addr_done;
  logic [shbd_pkg::ADDR_W-1:0] address;
  logic [shbd_pkg::BE_W-1:0] byte_en;

  modport decoder (
    output cmd_phase,
    output wide_mode,
    output line,
    input addr_done,
    input address,
    input byte_en
  );
  modport assembler (
    input cmd_phase,
    input wide_mode,
    input line,
    output addr_done,
    output address,
    output byte_en
  );
endinterface : shbd_phase_if

/* File: design/shbd_addr_assemble.sv */
// Address and byte-enable assembly for command phases
`timescale 1ns/1ps
module shbd_addr_assemble (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  shbd_phase_if.assembler ph
);
  shbd_pkg::shbd_seq_t seq_reg;
  logic [shbd_pkg::ADDR_W-1:0] addr_reg;
  logic [shbd_pkg::BE_W-1:0] be_reg;
  logic done_reg;

  // One byte lane selected by the low address bits
  function automatic logic [shbd_pkg::BE_W-1:0] lane_of(input logic [1:0] a);
    lane_of = shbd_pkg::BE_ONE << a;
  endfunction : lane_of

  // Narrow mode needs two command writes; wide mode takes one
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_reg <= shbd_pkg::SEQ_FIRST;
    end else if (ce && ph.cmd_phase && !ph.wide_mode) begin
      case (seq_reg)
        shbd_pkg::SEQ_FIRST: seq_reg <= shbd_pkg::SEQ_SECOND;
        shbd_pkg::SEQ_SECOND: seq_reg <= shbd_pkg::SEQ_FIRST;
        default: seq_reg <= shbd_pkg::SEQ_FIRST;
      endcase
    end
  end

  // Address and enables; line 11 and lines 1..0 never sampled in wide mode
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_reg <= shbd_pkg::ADDR_RST;
      be_reg <= shbd_pkg::BE_RST;
    end else if (ce && ph.cmd_phase) begin
      if (ph.wide_mode) begin
        addr_reg <= {ph.line[shbd_pkg::WIDE_A_MSB:shbd_pkg::WIDE_A_LSB], 2'b00};
        be_reg <= ph.line[shbd_pkg::BE_MSB:shbd_pkg::BE_LSB];
      end else if (seq_reg == shbd_pkg::SEQ_FIRST) begin
        addr_reg[shbd_pkg::NARROW_W-1:0] <= ph.line[shbd_pkg::NARROW_W-1:0];
        be_reg <= lane_of(ph.line[1:0]);
      end else begin
        // Lines 7..3 are don't care on the second write
        addr_reg[shbd_pkg::ADDR_W-1:shbd_pkg::ADDR_HIGH_LSB] <=
          ph.line[shbd_pkg::HIGH_A_MSB:shbd_pkg::HIGH_A_LSB];
      end
    end
  end

  // Completion pulse once a full address is held
  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= ph.cmd_phase && (ph.wide_mode || seq_reg == shbd_pkg::SEQ_SECOND);
    end
  end

  assign ph.addr_done = done_reg;
  assign ph.address = addr_reg;
  assign ph.byte_en = be_reg;
endmodule : shbd_addr_assemble

/* File: design/shbd_top.sv */
// Shared bus phase decoder with power-down handling
//
// Operation
// - Command input low means each shared line carries the same-index data bit.
// - Wide mode command phase: lines 15..12 are byte enables, fourth down to first.
// - Line 11 is ignored during command phases, data only otherwise.
// - Wide mode command phase: lines 10..2 carry address bits 10..2.
// - Narrow mode address needs two command writes; first gives bits 7..0.
// - Second narrow command write: lines 2..0 give address bits 10..8.
// - Wide mode command phase ignores lines 1 and 0, address word aligned.
// - Power-down input is active low; high or floating means normal run.
// - During power-down all pins float and all state returns to default; only the shared bus lines float here, the rest show reset values, powered_down high.
// - Leaving power-down equals leaving a hardware reset.
`timescale 1ns/1ps
module shbd_top (
  clk,
  rst,
  ce,
  chip_powerdown_n,
  wide_strap,
  phase_valid,
  cmd_type,
  shared_bus_line_in,
  shared_bus_line_out,
  shared_bus_line_oe,
  read_drive,
  read_data,
  data_valid,
  data_word,
  addr_valid,
  address,
  byte_lane_enable_first,
  byte_lane_enable_second,
  byte_lane_enable_third,
  byte_lane_enable_fourth,
  wide_mode,
  powered_down
);
  input wire logic clk;
  input wire logic rst;
  input wire logic ce;
  input wire logic chip_powerdown_n;
  input wire logic wide_strap;
  input wire logic phase_valid;
  input wire logic cmd_type;
  input wire logic [shbd_pkg::BUS_W-1:0] shared_bus_line_in;
  output logic [shbd_pkg::BUS_W-1:0] shared_bus_line_out;
  output logic [shbd_pkg::BUS_W-1:0] shared_bus_line_oe;
  input wire logic read_drive;
  input wire logic [shbd_pkg::BUS_W-1:0] read_data;
  output logic data_valid;
  output logic [shbd_pkg::BUS_W-1:0] data_word;
  output logic addr_valid;
  output logic [shbd_pkg::ADDR_W-1:0] address;
  output logic byte_lane_enable_first;
  output logic byte_lane_enable_second;
  output logic byte_lane_enable_third;
  output logic byte_lane_enable_fourth;
  output logic wide_mode;
  output logic powered_down;

  shbd_phase_if ph ();

  logic [shbd_pkg::SYNC_STAGES-1:0] pd_sync_reg;
  logic [shbd_pkg::SYNC_STAGES-1:0] strap_sync_reg;
  logic [shbd_pkg::SYNC_STAGES-1:0] strap_age_reg;
  logic pd_active;
  logic core_rst;
  logic wide_reg;
  logic width_taken_reg;
  logic data_valid_reg;
  logic [shbd_pkg::BUS_W-1:0] data_word_reg;
  logic [shbd_pkg::BUS_W-1:0] out_reg;
  logic [shbd_pkg::BUS_W-1:0] oe_reg;

  // Lanes that take part in transfers for the current width
  function automatic logic [shbd_pkg::BUS_W-1:0] lane_mask(input logic wide);
    lane_mask = wide ? 16'hFFFF : 16'h00FF;
  endfunction : lane_mask

  // Power-down pin is asynchronous; synchroniser reset to the run level
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_sync_reg <= ~shbd_pkg::SYNC_RST;
    end else begin
      pd_sync_reg <= {pd_sync_reg[0], chip_powerdown_n};
    end
  end

  // Low level powers down; undriven pin is pulled high at the pad
  assign pd_active = ~pd_sync_reg[1];
  // Power-down acts as a reset, so release lands in the reset state
  assign core_rst = rst | pd_active;

  // Width strap is a pin too
  always_ff @(posedge clk) begin
    if (core_rst) begin
      strap_sync_reg <= shbd_pkg::SYNC_RST;
    end else if (ce) begin
      strap_sync_reg <= {strap_sync_reg[0], wide_strap};
    end
  end

  // Capture waits for the strap to pass both sync flops, else it reads the reset level
  always_ff @(posedge clk) begin
    if (core_rst) begin
      strap_age_reg <= shbd_pkg::SYNC_RST;
    end else if (ce) begin
      strap_age_reg <= {strap_age_reg[0], 1'b1};
    end
  end

  // Width taken once after reset; later strap changes are ignored
  always_ff @(posedge clk) begin
    if (core_rst) begin
      wide_reg <= 1'b0;
      width_taken_reg <= 1'b0;
    end else if (ce && !width_taken_reg && strap_age_reg[1]) begin
      wide_reg <= strap_sync_reg[1];
      width_taken_reg <= 1'b1;
    end
  end

  // Phases before the width is known are dropped
  assign ph.cmd_phase = phase_valid & cmd_type & width_taken_reg;
  assign ph.wide_mode = wide_reg;
  assign ph.line = shared_bus_line_in;

  shbd_addr_assemble shbd_addr_assemble_i (
    .clk(clk),
    .rst(core_rst),
    .ce(ce),
    .ph(ph)
  );

  // Data phase: same-index bits; narrow mode keeps only the low byte
  always_ff @(posedge clk) begin
    if (core_rst) begin
      data_word_reg <= shbd_pkg::BUS_RST;
      data_valid_reg <= 1'b0;
    end else if (ce) begin
      data_valid_reg <= phase_valid & ~cmd_type & width_taken_reg;
      if (phase_valid && !cmd_type && width_taken_reg) begin
        data_word_reg <= shared_bus_line_in & lane_mask(wide_reg);
      end
    end
  end

  // Read drive; upper lanes never driven in narrow mode since host holds them low
  always_ff @(posedge clk) begin
    if (core_rst) begin
      out_reg <= shbd_pkg::BUS_RST;
      oe_reg <= shbd_pkg::BUS_RST;
    end else if (ce) begin
      out_reg <= read_data & lane_mask(wide_reg);
      oe_reg <= (read_drive && width_taken_reg) ? lane_mask(wide_reg) : shbd_pkg::BUS_RST;
    end
  end

  // Enables gated combinationally so pins float the cycle power-down is seen
  assign shared_bus_line_oe = pd_active ? shbd_pkg::BUS_RST : oe_reg;
  assign shared_bus_line_out = out_reg;

  assign data_valid = data_valid_reg;
  assign data_word = data_word_reg;
  assign addr_valid = ph.addr_done;
  assign address = ph.address;
  // Byte enables, wide mode first lane from line 12 up to fourth from line 15; narrow mode decodes lines 1..0
  assign byte_lane_enable_first = ph.byte_en[0];
  assign byte_lane_enable_second = ph.byte_en[1];
  assign byte_lane_enable_third = ph.byte_en[2];
  assign byte_lane_enable_fourth = ph.byte_en[3];
  assign wide_mode = wide_reg;
  assign powered_down = pd_active;
endmodule : shbd_top

/* File: verification/shbd_chk_assertions.sv */
// Port-level assertions for the shared bus phase decoder
`timescale 1ns/1ps
module shbd_chk (
  clk,
  rst,
  chip_powerdown_n,
  phase_valid,
  cmd_type,
  shared_bus_line_in,
  shared_bus_line_oe,
  data_valid,
  data_word,
  addr_valid,
  address,
  wide_mode,
  powered_down
);
  input wire logic clk;
  input wire logic rst;
  input wire logic chip_powerdown_n;
  input wire logic phase_valid;
  input wire logic cmd_type;
  input wire logic data_valid;
  input wire logic addr_valid;
  input wire logic wide_mode;
  input wire logic powered_down;
  input wire logic [15:0] shared_bus_line_in;
  input wire logic [15:0] shared_bus_line_oe;
  input wire logic [15:0] data_word;
  input wire logic [10:0] address;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Each result pulse must trace back to a phase one cycle earlier
  property p_dv_cause; data_valid |-> $past(phase_valid && !cmd_type); endproperty
  a_dv_cause: assert property (p_dv_cause) else $error("data pulse without phase");
  property p_dv_word; data_valid |-> data_word == (wide_mode ? $past(shared_bus_line_in)
    : {8'h00, $past(shared_bus_line_in[7:0])}); endproperty
  a_dv_word: assert property (p_dv_word) else $error("data word mismatch");
  property p_av_cause; addr_valid |-> $past(phase_valid && cmd_type); endproperty
  a_av_cause: assert property (p_av_cause) else $error("address pulse without phase");
  property p_wide_addr; addr_valid && wide_mode
    |-> address == {$past(shared_bus_line_in[10:2]), 2'b00}; endproperty
  a_wide_addr: assert property (p_wide_addr) else $error("wide address wrong");
  property p_narrow_hi; addr_valid && !wide_mode
    |-> address[10:8] == $past(shared_bus_line_in[2:0]); endproperty
  a_narrow_hi: assert property (p_narrow_hi) else $error("narrow high bits wrong");
  // Output enables stay off for the whole power-down
  property p_pd_float; powered_down |-> shared_bus_line_oe == 16'h0000; endproperty
  a_pd_float: assert property (p_pd_float) else $error("pins driven in power-down");
  property p_pd_clear; powered_down && $past(powered_down)
    |-> !data_valid && !addr_valid && address == 11'h000; endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("state kept in power-down");
  // Four low samples cover the two-flop synchroniser
  property p_pd_enter; !chip_powerdown_n [*4] |-> powered_down; endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
endmodule : shbd_chk
bind shbd_top shbd_chk shbd_chk_i (.clk, .rst, .chip_powerdown_n, .phase_valid, .cmd_type,
  .shared_bus_line_in, .shared_bus_line_oe, .data_valid, .data_word, .addr_valid, .address,
  .wide_mode, .powered_down);

/* File: verification/shbd_host.sv */
// Host-side model driving write phases onto the shared lines
`timescale 1ns/1ps
module shbd_host (
  clk,
  wide,
  phase_valid,
  cmd_type,
  line
);
  input wire logic clk;
  input wire logic wide;
  output logic phase_valid = 1'b0;
  output logic cmd_type = 1'b0;
  output logic [15:0] line = 16'h0000;
  // One write phase; a narrow host keeps the upper byte low
  task wr(input logic c, input logic [15:0] v);
    @(posedge clk);
    phase_valid <= 1'b1;
    cmd_type <= c;
    line <= wide ? v : {8'h00, v[7:0]};
    @(posedge clk);
    phase_valid <= 1'b0;
    cmd_type <= 1'b0;
    line <= wide ? 16'h01f1 : 16'h00f1; // Released lines settle at their pull levels
  endtask : wr
endmodule : shbd_host

/* File: verification/shbd_top_tb.sv */
// Self-checking bench for the shared bus phase decoder
`timescale 1ns/1ps
module shbd_top_tb;
  logic clk, rst, ce, chip_powerdown_n, wide_strap, read_drive, phase_valid, cmd_type;
  logic data_valid, addr_valid, wide_mode, powered_down, byte_lane_enable_first;
  logic byte_lane_enable_second, byte_lane_enable_third, byte_lane_enable_fourth;
  logic [15:0] host_line, shared_bus_line_in, shared_bus_line_out, shared_bus_line_oe;
  logic [15:0] read_data, data_word;
  logic [10:0] address;
  int num_errors = 0;
  int n_checks = 0;
  // Wire level: OR of the host lines and the enabled read lanes; no pull-down, released host lines hold their idle value
  assign shared_bus_line_in = host_line | (shared_bus_line_out & shared_bus_line_oe);
  shbd_top shbd_top_i (.clk, .rst, .ce, .chip_powerdown_n, .wide_strap, .phase_valid,
    .cmd_type, .shared_bus_line_in, .shared_bus_line_out, .shared_bus_line_oe, .read_drive,
    .read_data, .data_valid, .data_word, .addr_valid, .address, .byte_lane_enable_first,
    .byte_lane_enable_second, .byte_lane_enable_third, .byte_lane_enable_fourth, .wide_mode,
    .powered_down);
  shbd_host host_i (.clk, .wide(wide_strap), .phase_valid, .cmd_type, .line(host_line));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Reset with a chosen strap, then wait past the width capture
  task start(input logic w);
    @(posedge clk);
    rst <= 1'b1;
    wide_strap <= w;
    cyc(12);
    rst <= 1'b0;
    cyc(4);
    #1 chk("wide_mode", wide_mode, w);
  endtask : start
  // Drive a read word for two cycles, then release
  task rd(input logic [15:0] m);
    @(posedge clk);
    read_drive <= 1'b1;
    read_data <= 16'h1234;
    @(posedge clk);
    #1 chk("oe", shared_bus_line_oe, m);
    chk("out", shared_bus_line_out & m, 16'h1234 & m);
    @(posedge clk);
    read_drive <= 1'b0;
    @(posedge clk);
    #1 chk("oe_off", shared_bus_line_oe, 0);
  endtask : rd
  task t_wide;
    start(1'b1);
    host_i.wr(1'b0, 16'ha5c3);
    #1 chk("data_valid", data_valid, 1);
    chk("data_word", data_word, 16'ha5c3);
    host_i.wr(1'b1, 16'h5bff);
    #1 chk("addr_valid", addr_valid, 1);
    chk("address", address, 11'h3fc);
    chk("byte_en", {byte_lane_enable_fourth, byte_lane_enable_third,
      byte_lane_enable_second, byte_lane_enable_first}, 4'h5);
    host_i.wr(1'b0, 16'h0800);
    #1 chk("data_word", data_word, 16'h0800);
    @(posedge clk);
    ce <= 1'b0;
    host_i.wr(1'b0, 16'h00ff);
    #1 chk("frozen", data_word, 16'h0800);
    @(posedge clk);
    ce <= 1'b1;
    rd(16'hffff);
  endtask : t_wide
  // Narrow address in two writes with a data phase between them
  task t_narrow;
    start(1'b0);
    host_i.wr(1'b1, 16'hffa7);
    #1 chk("addr_valid", addr_valid, 0);
    chk("addr_low", address[7:0], 8'ha7);
    chk("byte_en", {byte_lane_enable_fourth, byte_lane_enable_third,
      byte_lane_enable_second, byte_lane_enable_first}, 4'h8);
    host_i.wr(1'b0, 16'h00c4);
    #1 chk("data_word", data_word, 16'h00c4);
    host_i.wr(1'b1, 16'h00fd);
    #1 chk("addr_valid", addr_valid, 1);
    chk("address", address, 11'h5a7);
    rd(16'h00ff);
  endtask : t_narrow
  // Power-down with a pending read, new strap seen on release
  task t_pdown;
    int i;
    @(posedge clk);
    chip_powerdown_n <= 1'b0;
    read_drive <= 1'b1;
    wide_strap <= 1'b1;
    cyc(4);
    #1 chk("powered_down", powered_down, 1);
    chk("oe", shared_bus_line_oe, 0);
    chk("address", address, 0);
    @(posedge clk);
    chip_powerdown_n <= 1'b1;
    read_drive <= 1'b0;
    for (i = 0; i < 8 && powered_down !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (powered_down !== 1'b0) begin
      num_errors++;
      stop_test;
    end
    cyc(5);
    #1 chk("wide_mode", wide_mode, 1);
    host_i.wr(1'b0, 16'hbeef);
    #1 chk("data_word", data_word, 16'hbeef);
  endtask : t_pdown
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    chip_powerdown_n = 1'b1;
    wide_strap = 1'b1;
    read_drive = 1'b0;
    read_data = 16'h0000;
    t_wide;
    t_narrow;
    t_pdown;
    stop_test;
  end
endmodule : shbd_top_tb
